// *** core/ucpmc_mode_ctrl.sv ***
// Contract
// - entering automatic mode presents the first divider first
// - shorted-line device in auto: discharge, power back on, then shorted scheme
// - stay shorted until lines released, then back to first divider
// - charge current over threshold moves first divider to second
// - after retest keep second divider if current stays high, else first
// - first divider: D+ low level, D- high; second swaps them
// - shorted scheme ties D+ to D- under the impedance limit
// - forced modes hold one scheme, no automatic switching
// - pass switches close only in data modes with enable high
// - charging downstream keeps switches closed during handshake
// - switches open on enable low, pins 000, or dedicated modes
// - current limiting alone never opens the pass switches
// - reset holds initial state with output discharging
// - after reset go to the state the mode pins select
// - discharge sequence: power off, discharge output, power back on
// - retention only for 111X or 010X to 011X, low-speed devices only
// - watch D- always; D- high at idle means low-speed device (code watches it only in data modes with switches closed)
// - with low-speed device seen, ignore change to auto and keep mode
// - D- low restarts countdown; expiry with pins 011X enters auto mode
// - no retention for full-speed devices
// - mode pins decode per the fixed pattern table
// - no discharge between 1111 and 1110
// - enable low: switches and power off, output discharging
`timescale 1ns/1ps
`default_nettype none
module ucpmc_mode_ctrl #(
   parameter int unsigned WAKE_CYCLES = ucpmc_pkg::WAKE_CYCLES_DFLT
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // host control pins
   input wire logic modeSelA,
   input wire logic modeSelB,
   input wire logic modeSelC,
   input wire logic currentRangeSelect,
   input wire logic enable,
   // analog sense from the port side
   input wire logic dpHigh,
   input wire logic dmHigh,
   input wire logic shortDevAttach,
   input wire logic linesReleased,
   input wire logic chargeOverThreshold,
   // power path
   output logic powerSwitchOn,
   output logic outDischarge,
   output logic ilimHighSel,
   // data lines
   output logic dataSwitchOn,
   output logic dpAt2v0,
   output logic dpAt2v7,
   output logic dmAt2v0,
   output logic dmAt2v7,
   output logic linesShorted,
   // wake retention status
   output logic wakeHold
);
   import ucpmc_pkg::*;

   typedef struct packed {
      ucpmc_state_e st;
      ucpmc_mode_e mode;
      ucpmc_scheme_e scheme;
      logic divTest;
      logic hold;
      logic lsHid;
      logic [2:0] prevCtl;
      logic dmPrev;
      logic powerOn;
      logic disch;
      logic dataSw;
      logic ilimHi;
   } ucpmc_ctl_s;

   ucpmc_ctl_s q;
   ucpmc_ctl_s d;

   logic [2:0] ctl;
   ucpmc_mode_e pinMode;
   ucpmc_mode_e target;
   logic holdNow;
   logic pairSwap;
   logic dischLoad;
   logic [TMR_W-1:0] dischVal;
   logic dischBusy;
   logic wakeLoad;
   logic [TMR_W-1:0] wakeVal;
   logic wakeDone;
   ucpmc_scheme_e sigSel;

   ////////////////////////////////////////////////////////////////////////
   // timers

   ucpmc_countdown u_disch_tmr (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(dischLoad),
      .loadVal(dischVal),
      .busy(dischBusy),
      .done()
   );

   ucpmc_countdown u_wake_tmr (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .load(wakeLoad),
      .loadVal(wakeVal),
      .busy(),
      .done(wakeDone)
   );

   ////////////////////////////////////////////////////////////////////////
   // control

   assign ctl = {modeSelA, modeSelB, modeSelC};
   assign pinMode = ucpmc_decode(ctl, currentRangeSelect);

   // retention, mode selection and the charging state machine
   always_comb begin
      d = q;
      dischLoad = 1'b0;
      dischVal = TMR_W'(DISCH_CYCLES);
      wakeLoad = 1'b0;
      wakeVal = TMR_W'(WAKE_CYCLES);
      d.prevCtl = ctl;
      d.dmPrev = dmHigh;

      // D+ high at idle marks full speed, so it never counts
      if (ucpmc_data_mode(q.mode) && q.dataSw && dmHigh && !dpHigh) begin
         d.lsHid = 1'b1;
      end else if (!ucpmc_data_mode(q.mode)) begin
         d.lsHid = 1'b0;
      end

      // retention starts only on the documented pin transitions
      holdNow = q.hold;
      if (!q.hold && q.st == ST_ON && ctl == CTL_AUTO_WAKE && q.lsHid && ucpmc_data_mode(q.mode) &&
          (q.prevCtl == CTL_CDP_GRP || q.prevCtl == CTL_SDP_WAKE)) begin
         holdNow = 1'b1;
      end
      if (holdNow && ctl != CTL_AUTO_WAKE) begin
         holdNow = 1'b0;
         wakeLoad = 1'b1;
         wakeVal = '0;
      end else if (q.hold && wakeDone) begin
         holdNow = 1'b0;
      end else if (holdNow && q.dmPrev && !dmHigh) begin
         wakeLoad = 1'b1;
      end
      d.hold = holdNow;
      target = holdNow ? q.mode : pinMode;
      pairSwap = (q.mode == M_CDP && target == M_STANDARD_PORT_WAKE_B) || (q.mode == M_STANDARD_PORT_WAKE_B && target == M_CDP);

      unique case (q.st)
         ST_INIT: begin
            d.mode = target;
            d.scheme = SCH_DIV1;
            d.divTest = 1'b0;
            d.st = ST_DISCH;
            dischLoad = 1'b1;
         end
         ST_DISCH: begin
            if (target != q.mode) begin
               d.mode = target;
               d.scheme = SCH_DIV1;
               d.divTest = 1'b0;
               dischLoad = 1'b1;
            end else if (!enable || q.mode == M_DISCH) begin
               dischLoad = 1'b1;
            end else if (!dischBusy) begin
               d.st = ST_ON;
            end
         end
         ST_ON: begin
            if (!enable || (target != q.mode && !pairSwap)) begin
               d.st = ST_DISCH;
               if (target != q.mode) begin
                  d.scheme = SCH_DIV1;
               end
               d.mode = target;
               d.divTest = 1'b0;
               dischLoad = 1'b1;
            end else if (pairSwap) begin
               d.mode = target;
            end else if (q.mode == M_AUTO) begin
               unique case (q.scheme)
                  SCH_DIV1: begin
                     if (shortDevAttach) begin
                        d.scheme = SCH_SHORT;
                        d.st = ST_DISCH;
                        dischLoad = 1'b1;
                     end else if (chargeOverThreshold) begin
                        d.scheme = SCH_DIV2;
                        d.divTest = 1'b1;
                        dischLoad = 1'b1;
                        dischVal = TMR_W'(DIV_TEST_CYCLES);
                     end
                  end
                  SCH_DIV2: begin
                     if (q.divTest && !dischBusy) begin
                        d.divTest = 1'b0;
                        if (!chargeOverThreshold) begin
                           d.scheme = SCH_DIV1;
                        end
                     end
                  end
                  SCH_SHORT: begin
                     if (linesReleased) begin
                        d.scheme = SCH_DIV1;
                     end
                  end
                  default: d.scheme = SCH_DIV1;
               endcase
            end
         end
         default: d.st = ST_INIT;
      endcase

      // power path and switches follow the next state
      d.powerOn = (d.st == ST_ON);
      d.disch = (d.st != ST_ON);
      // current limit state is not an input here, so it cannot open them
      d.dataSw = enable && ucpmc_data_mode(d.mode);
      d.ilimHi = currentRangeSelect || d.mode == M_AUTO || d.mode == M_CDP;
   end

   // discharge and initial state are the reset image
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         q <= '0;
         q.disch <= 1'b1;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // signature and outputs

   // no scheme is selected while the output discharges; the registered drive stage follows one cycle later
   always_comb begin
      sigSel = SCH_NONE;
      if (q.st == ST_ON) begin
         unique case (q.mode)
            M_AUTO: sigSel = q.scheme;
            M_FSHORT: sigSel = SCH_SHORT;
            M_FDIV1: sigSel = SCH_DIV1;
            default: sigSel = SCH_NONE;
         endcase
      end
   end

   ucpmc_sig_drive u_sig (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .scheme(sigSel),
      .dpAt2v0(dpAt2v0),
      .dpAt2v7(dpAt2v7),
      .dmAt2v0(dmAt2v0),
      .dmAt2v7(dmAt2v7),
      .linesShorted(linesShorted)
   );

   assign powerSwitchOn = q.powerOn;
   assign outDischarge = q.disch;
   assign ilimHighSel = q.ilimHi;
   assign dataSwitchOn = q.dataSw;
   assign wakeHold = q.hold;

   ////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_reset_initial: assert property (disable iff (1'b0) sys_rst |=> q.st == ST_INIT && outDischarge && !powerSwitchOn)
      else $error("reset did not hold initial discharging state");

   a_init_leaves: assert property (q.st == ST_INIT |=> q.st == ST_DISCH && q.mode == $past(pinMode))
      else $error("initial state not left for pin mode");

   a_disch_sequence: assert property (q.st == ST_ON && d.st == ST_DISCH |=> !powerSwitchOn && outDischarge ##1 !powerSwitchOn)
      else $error("discharge sequence did not drop power");

   a_switch_enable: assert property (!enable |=> !dataSwitchOn)
      else $error("pass switches closed with enable low");

   a_switch_cdp: assert property (enable && d.mode == M_CDP |=> dataSwitchOn)
      else $error("pass switches open in charging downstream mode");

   a_auto_first: assert property (q.mode != M_AUTO && d.mode == M_AUTO |=> q.scheme == SCH_DIV1)
      else $error("automatic mode did not start on first divider");

   a_div_up: assert property (q.st == ST_ON && d.st == ST_ON && q.mode == M_AUTO && d.mode == M_AUTO &&
                              q.scheme == SCH_DIV1 && !shortDevAttach && chargeOverThreshold |=>
                              q.scheme == SCH_DIV2 ##1 q.scheme == SCH_DIV2)
      else $error("high current did not select second divider");

   a_pair_nodisch: assert property (q.st == ST_ON && enable && pairSwap |=> q.st == ST_ON && powerSwitchOn)
      else $error("discharge between 1111 and 1110");

   a_wake_expire: assert property (q.hold && wakeDone && ctl == CTL_AUTO_WAKE && q.mode != M_AUTO |=>
                                   !q.hold && q.st == ST_DISCH && q.mode == M_AUTO)
      else $error("countdown expiry did not enter automatic mode");

   a_hold_keeps: assert property (q.hold && !wakeDone && ctl == CTL_AUTO_WAKE && q.st == ST_ON && enable |=>
                                  q.st == ST_ON && ucpmc_data_mode(q.mode))
      else $error("retention lost the data mode");
endmodule
`default_nettype wire

// *** core/ucpmc_pkg.sv ***
`default_nettype none
package ucpmc_pkg;
   // core clock rate
   localparam int unsigned CLK_KHZ = 20000;
   // output discharge hold, least time, rounded up
   localparam int unsigned DISCH_US = 100;
   localparam int unsigned DISCH_CYCLES = (DISCH_US * CLK_KHZ + 999) / 1000;
   // high current retest window after moving to the second divider
   localparam int unsigned DIV_TEST_US = 200;
   localparam int unsigned DIV_TEST_CYCLES = (DIV_TEST_US * CLK_KHZ + 999) / 1000;
   // wake retention countdown, longest time, rounded down
   localparam int unsigned WAKE_MS = 64;
   localparam int unsigned WAKE_CYCLES_DFLT = WAKE_MS * CLK_KHZ;
   localparam int unsigned TMR_W = 21;
   // analog figures carried by the comparators and switches outside
   localparam int unsigned CHARGE_THRESH_MA = 750;
   localparam int unsigned SHORT_MAX_OHM = 200;
   localparam int unsigned DIV_LOW_MV = 2000;
   localparam int unsigned DIV_HIGH_MV = 2700;
   // mode pin patterns, mode_sel_a first
   localparam logic [2:0] CTL_AUTO_WAKE = 3'h3;
   localparam logic [2:0] CTL_CDP_GRP = 3'h7;
   localparam logic [2:0] CTL_SDP_WAKE = 3'h2;

   typedef enum logic [2:0] {
      M_DISCH = 3'b000,
      M_AUTO = 3'b001,
      M_SDP = 3'b010,
      M_STANDARD_PORT_WAKE_B = 3'b011,
      M_CDP = 3'b100,
      M_FSHORT = 3'b101,
      M_FDIV1 = 3'b110
   } ucpmc_mode_e;

   typedef enum logic [1:0] {
      ST_INIT = 2'b00,
      ST_DISCH = 2'b01,
      ST_ON = 2'b10
   } ucpmc_state_e;

   typedef enum logic [1:0] {
      SCH_NONE = 2'b00,
      SCH_SHORT = 2'b01,
      SCH_DIV1 = 2'b10,
      SCH_DIV2 = 2'b11
   } ucpmc_scheme_e;

   // mode pins plus current range select to charging mode
   function automatic ucpmc_mode_e ucpmc_decode(input logic [2:0] ctl, input logic ilim);
      ucpmc_mode_e m;
      m = M_DISCH;
      case (ctl)
         3'h1, 3'h3: m = M_AUTO;
         3'h2, 3'h6: m = M_SDP;
         3'h4: m = M_FSHORT;
         3'h5: m = M_FDIV1;
         3'h7: m = ilim ? M_CDP : M_STANDARD_PORT_WAKE_B;
         default: m = M_DISCH;
      endcase
      return m;
   endfunction

   // modes that pass the data lines through
   function automatic logic ucpmc_data_mode(input ucpmc_mode_e m);
      return (m == M_SDP) || (m == M_STANDARD_PORT_WAKE_B) || (m == M_CDP);
   endfunction
endpackage
`default_nettype wire

// *** core/ucpmc_countdown.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucpmc_countdown (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // load a start value, zero clears
   input wire logic load,
   input wire logic [ucpmc_pkg::TMR_W-1:0] loadVal,
   // state
   output logic busy,
   output logic done
);
   import ucpmc_pkg::*;

   typedef struct packed {
      logic [TMR_W-1:0] cnt;
      logic done;
   } ucpmc_cd_s;

   ucpmc_cd_s q;
   ucpmc_cd_s d;

   // reload wins over counting so a restart never loses time
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (load) begin
         d.cnt = loadVal;
      end else if (q.cnt != '0) begin
         d.cnt = q.cnt - TMR_W'(1);
         d.done = (q.cnt == TMR_W'(1));
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign busy = (q.cnt != '0);
   assign done = q.done;
endmodule
`default_nettype wire

// *** core/ucpmc_sig_drive.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucpmc_sig_drive (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // scheme to present
   input wire ucpmc_pkg::ucpmc_scheme_e scheme,
   // data line bias switches
   output logic dpAt2v0,
   output logic dpAt2v7,
   output logic dmAt2v0,
   output logic dmAt2v7,
   output logic linesShorted
);
   import ucpmc_pkg::*;

   typedef struct packed {
      logic dp20;
      logic dp27;
      logic dm20;
      logic dm27;
      logic shorted;
   } ucpmc_sig_s;

   ucpmc_sig_s q;
   ucpmc_sig_s d;

   // one bias source per line, never both
   always_comb begin
      d = '0;
      unique case (scheme)
         SCH_DIV1: begin
            d.dp20 = 1'b1;
            d.dm27 = 1'b1;
         end
         SCH_DIV2: begin
            d.dp27 = 1'b1;
            d.dm20 = 1'b1;
         end
         SCH_SHORT: d.shorted = 1'b1; // switch sized below SHORT_MAX_OHM
         SCH_NONE: d = '0;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign dpAt2v0 = q.dp20;
   assign dpAt2v7 = q.dp27;
   assign dmAt2v0 = q.dm20;
   assign dmAt2v7 = q.dm27;
   assign linesShorted = q.shorted;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_swap_levels: assert property (scheme == SCH_DIV2 |=> dpAt2v7 && dmAt2v0 && !dpAt2v0 && !dmAt2v7)
      else $error("second divider levels not swapped");
endmodule
`default_nettype wire

// *** test/ucpmc_port_dev.sv ***
`timescale 1ns/1ps
`default_nettype none
module ucpmc_port_dev (
   // clock
   input wire logic core_clk,
   // port power and line bias from the block
   input wire logic powerSwitchOn,
   input wire logic dataSwitchOn,
   input wire logic [4:0] sig,
   // scenario controls: 1 shorted, 2 fast divider, 3 slow divider, 4 low speed, 5 full speed
   input wire logic [2:0] kind,
   input wire logic click,
   input wire logic letGo,
   // sensed by the block
   output logic dpHigh,
   output logic dmHigh,
   output logic shortDevAttach,
   output logic linesReleased,
   output logic chargeOverThreshold
);
   logic triedDiv2 = 1'b0;
   wire logic div1 = (sig == 5'h12);
   wire logic div2 = (sig == 5'h0C);
   ////////////////////////////////////////
   // slow divider device forgets its retry only when power drops
   always @(posedge core_clk) begin
      triedDiv2 <= powerSwitchOn & (triedDiv2 | div2);
   end
   // low speed idle pulls D- high, a click drops it
   assign dmHigh = (kind == 3'h4) & dataSwitchOn & !click;
   assign dpHigh = (kind == 3'h5) & dataSwitchOn;
   // shorted-line device only answers the first divider while powered
   assign shortDevAttach = (kind == 3'h1) & powerSwitchOn & div1 & !letGo;
   assign linesReleased = (kind == 3'h1) & letGo;
   // slow device draws high current only before it has seen the second divider
   assign chargeOverThreshold = powerSwitchOn & (((kind == 3'h2) & (div1 | div2))
      | ((kind == 3'h3) & div1 & !triedDiv2));
endmodule
`default_nettype wire

// *** test/usb_charge_port_mode_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module usb_charge_port_mode_control_test;
   import ucpmc_pkg::*;
   localparam int WAKE = 200;
   localparam int DEADLINE = 60000;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [3:0] pins = 4'h4;
   logic enable = 1'b1;
   logic [2:0] kind = 3'h0;
   logic click = 1'b0;
   logic letGo = 1'b0;
   logic dpHigh, dmHigh, shortDevAttach, linesReleased, chargeOverThreshold;
   logic powerSwitchOn, outDischarge, ilimHighSel, dataSwitchOn, wakeHold;
   logic dpAt2v0, dpAt2v7, dmAt2v0, dmAt2v7, linesShorted;
   wire logic [4:0] sig = {dpAt2v0, dpAt2v7, dmAt2v0, dmAt2v7, linesShorted};
   int badCount = 0;
   int nCompared = 0;
   int cycles = 0;
   ////////////////////////////////////////
   // pins are {modeSelA, modeSelB, modeSelC, currentRangeSelect}
   ucpmc_mode_ctrl #(.WAKE_CYCLES(WAKE)) i_ucpmc_mode_ctrl (.core_clk(core_clk), .sys_rst(sys_rst),
      .modeSelA(pins[3]), .modeSelB(pins[2]), .modeSelC(pins[1]), .currentRangeSelect(pins[0]),
      .enable(enable), .dpHigh(dpHigh), .dmHigh(dmHigh), .shortDevAttach(shortDevAttach),
      .linesReleased(linesReleased), .chargeOverThreshold(chargeOverThreshold),
      .powerSwitchOn(powerSwitchOn), .outDischarge(outDischarge), .ilimHighSel(ilimHighSel),
      .dataSwitchOn(dataSwitchOn), .dpAt2v0(dpAt2v0), .dpAt2v7(dpAt2v7), .dmAt2v0(dmAt2v0),
      .dmAt2v7(dmAt2v7), .linesShorted(linesShorted), .wakeHold(wakeHold));
   ucpmc_port_dev i_ucpmc_port_dev (.core_clk(core_clk), .powerSwitchOn(powerSwitchOn),
      .dataSwitchOn(dataSwitchOn), .sig(sig), .kind(kind), .click(click), .letGo(letGo),
      .dpHigh(dpHigh), .dmHigh(dmHigh), .shortDevAttach(shortDevAttach),
      .linesReleased(linesReleased), .chargeOverThreshold(chargeOverThreshold));
   ////////////////////////////////////////
   // clock and hang guard
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == DEADLINE) begin
         badCount++;
         conclude();
      end
   end
   ////////////////////////////////////////
   // shared helpers
   task automatic conclude();
      $display("compared %0d mismatches %0d", nCompared, badCount);
      if (badCount == 0 && nCompared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
      nCompared++;
      if (seen !== exp) begin
         badCount++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic setPins(input logic [3:0] p);
      @(posedge core_clk);
      pins <= p;
      #1;
   endtask
   task automatic setKind(input logic [2:0] k);
      @(posedge core_clk);
      kind <= k;
      #1;
   endtask
   // a click drops D- for three cycles
   task automatic pulseClick();
      @(posedge core_clk);
      click <= 1'b1;
      repeat (3) @(posedge core_clk);
      click <= 1'b0;
      #1;
   endtask
   // bounded wait for the end of a discharge
   task automatic powerUp();
      int n;
      n = 0;
      while (powerSwitchOn !== 1'b1 && n < DISCH_CYCLES + 100) begin
         tick(1);
         n++;
      end
      tick(2);
      check("power", 5'(powerSwitchOn), 5'h1);
      check("discharge", 5'(outDischarge), 5'h0);
   endtask
   task automatic offCheck();
      tick(2);
      check("power off", 5'(powerSwitchOn), 5'h0);
      check("discharging", 5'(outDischarge), 5'h1);
   endtask
   ////////////////////////////////////////
   // scenarios
   task automatic tReset();
      check("reset disch", 5'(outDischarge), 5'h1);
      check("reset power", 5'(powerSwitchOn), 5'h0);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      powerUp();
      check("sdp data", 5'(dataSwitchOn), 5'h1);
      check("sdp ilim", 5'(ilimHighSel), 5'h0);
   endtask
   task automatic tForced();
      setPins(4'hA);
      offCheck();
      check("no sig in disch", sig, 5'h00);
      check("forced data", 5'(dataSwitchOn), 5'h0);
      powerUp();
      check("forced div1", sig, 5'h12);
      setKind(3'h2);
      tick(10);
      check("forced no switch", sig, 5'h12);
      setKind(3'h0);
      setPins(4'h8);
      offCheck();
      powerUp();
      check("forced short", sig, 5'h01);
   endtask
   task automatic tAuto();
      setPins(4'h2);
      offCheck();
      powerUp();
      check("auto first", sig, 5'h12);
      check("auto data", 5'(dataSwitchOn), 5'h0);
      check("auto ilim", 5'(ilimHighSel), 5'h1);
      setKind(3'h3);
      tick(3);
      check("slow div2", sig, 5'h0C);
      tick(DIV_TEST_CYCLES + 50);
      check("slow back", sig, 5'h12);
      setKind(3'h1);
      offCheck();
      powerUp();
      check("shorted", sig, 5'h01);
      @(posedge core_clk);
      letGo <= 1'b1;
      tick(3);
      check("released", sig, 5'h12);
      check("release power", 5'(powerSwitchOn), 5'h1);
      @(posedge core_clk);
      letGo <= 1'b0;
      kind <= 3'h2;
      tick(3);
      check("fast div2", sig, 5'h0C);
      tick(DIV_TEST_CYCLES + 50);
      check("fast keep", sig, 5'h0C);
   endtask
   task automatic tEnable();
      @(posedge core_clk);
      enable <= 1'b0;
      tick(2);
      check("en power", 5'(powerSwitchOn), 5'h0);
      check("en disch", 5'(outDischarge), 5'h1);
      check("en data", 5'(dataSwitchOn), 5'h0);
      @(posedge core_clk);
      enable <= 1'b1;
      pins <= 4'h4;
      powerUp();
      check("re data", 5'(dataSwitchOn), 5'h1);
      // 110 decodes to the same standard mode, so power must not drop
      setPins(4'hC);
      tick(3);
      check("sdp 110 power", 5'(powerSwitchOn), 5'h1);
      check("sdp 110 data", 5'(dataSwitchOn), 5'h1);
      setPins(4'h0);
      offCheck();
      check("zero data", 5'(dataSwitchOn), 5'h0);
      tick(DISCH_CYCLES + 100);
      check("zero held", 5'(powerSwitchOn), 5'h0);
   endtask
   task automatic tPair();
      setPins(4'hF);
      offCheck();
      powerUp();
      check("cdp ilim", 5'(ilimHighSel), 5'h1);
      setPins(4'hE);
      tick(3);
      check("pair power", 5'(powerSwitchOn), 5'h1);
      check("pair disch", 5'(outDischarge), 5'h0);
      check("standard_port_wake_b ilim", 5'(ilimHighSel), 5'h0);
      setPins(4'hF);
      tick(3);
      check("pair back", 5'(powerSwitchOn), 5'h1);
      check("cdp data", 5'(dataSwitchOn), 5'h1);
   endtask
   task automatic tWake();
      setKind(3'h4);
      tick(3);
      setPins(4'h6);
      tick(2);
      check("hold", 5'(wakeHold), 5'h1);
      check("hold data", 5'(dataSwitchOn), 5'h1);
      check("hold power", 5'(powerSwitchOn), 5'h1);
      pulseClick();
      tick(150);
      check("held", 5'(wakeHold), 5'h1);
      pulseClick();
      tick(150);
      check("restart", 5'(wakeHold), 5'h1);
      setPins(4'hF);
      tick(2);
      check("woken", 5'(wakeHold), 5'h0);
      check("woken data", 5'(dataSwitchOn), 5'h1);
      setPins(4'h6);
      tick(2);
      check("hold again", 5'(wakeHold), 5'h1);
      pulseClick();
      tick(WAKE + 20);
      check("expired", 5'(wakeHold), 5'h0);
      check("exp data", 5'(dataSwitchOn), 5'h0);
      check("exp disch", 5'(outDischarge), 5'h1);
      powerUp();
      check("exp auto", sig, 5'h12);
   endtask
   task automatic tFullSpeed();
      setKind(3'h5);
      setPins(4'h4);
      offCheck();
      powerUp();
      setPins(4'h6);
      tick(2);
      check("fs hold", 5'(wakeHold), 5'h0);
      check("fs data", 5'(dataSwitchOn), 5'h0);
      // second retention path: low speed device behind 010X going to 011X
      setKind(3'h4);
      setPins(4'h4);
      powerUp();
      setPins(4'h6);
      tick(2);
      check("standard_port_wake_a hold", 5'(wakeHold), 5'h1);
      check("standard_port_wake_a hold data", 5'(dataSwitchOn), 5'h1);
   endtask
   task automatic tMidReset();
      @(posedge core_clk);
      sys_rst <= 1'b1;
      tick(2);
      check("mid disch", 5'(outDischarge), 5'h1);
      check("mid power", 5'(powerSwitchOn), 5'h0);
      @(posedge core_clk);
      sys_rst <= 1'b0;
      powerUp();
      check("mid auto", sig, 5'h12);
   endtask
   ////////////////////////////////////////
   // main sequence, reset held for twelve cycles
   initial begin
      tick(11);
      tReset();
      tForced();
      tAuto();
      tEnable();
      tPair();
      tWake();
      tFullSpeed();
      tMidReset();
      conclude();
   end
endmodule
`default_nettype wire
